//--- src/rx_link_regs_pkg.sv
/*
  Constants, field layout and carrier types for the receive-side lane 7
  and link control register bank.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
package rx_link_regs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;
  localparam int unsigned LANES      = 8;
  localparam int unsigned LANE_IDX_W = 3;
  localparam int unsigned CFG_WORDS  = 4;
  localparam int unsigned WORD_IDX_W = 2;
  localparam int unsigned ERR_W      = 8;
  localparam int unsigned SEL_W      = 4;

  // ---------------------------------------------------------------
  // offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LANE7_CTRL_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] LINK_CTRL_OFS  = 8'h50;
  localparam logic [ADDR_W-1:0] REINIT_EN_OFS  = 8'h78;
  localparam logic [ADDR_W-1:0] CFG_WORD0_OFS  = 8'hA0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned LANE_INV_BIT   = 0;
  localparam int unsigned LANE_OFF_BIT   = 1;
  localparam int unsigned LANE_SPARE_BIT = 2;
  localparam int unsigned SEL_LO_BIT     = 7;
  localparam int unsigned SPARE0_BIT     = 11;
  localparam int unsigned REINIT_DIS_BIT = 12;
  localparam int unsigned SPARE1_BIT     = 13;
  localparam int unsigned SPARE4_BIT     = 16;
  localparam int unsigned CODE_GRP_BIT   = 0;
  localparam logic [LANE_IDX_W-1:0] LANE_SEVEN = 3'h7;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] LANE7_CTRL_RST  = 32'h0000_0004;
  localparam logic [DATA_W-1:0] LANE7_CTRL_MASK = 32'h0000_0007;
  localparam logic [DATA_W-1:0] LINK_CTRL_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] LINK_CTRL_MASK  = 32'h0001_FF80;
  localparam logic [DATA_W-1:0] REINIT_EN_RST   = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] REINIT_EN_MASK  = 32'h0000_00FF;
  localparam logic [ERR_W-1:0]  CODE_GRP_ONLY   = 8'h01;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } avs_req_t;

  typedef struct packed {
    logic              waitrequest;
    logic [DATA_W-1:0] readdata;
  } avs_rsp_t;

  typedef struct packed {
    logic                             valid;
    logic [CFG_WORDS-1:0][DATA_W-1:0] words;
  } lane_cfg_t;

endpackage

//--- src/rx_link_regs.sv
/*
  Lane 7 control, link control and per-error reinit enable registers,
  plus per-lane capture of alignment configuration words.
  Assumes all inputs are synchronous to mclk and a master that holds
  its request until waitrequest is low.
*/
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module rx_link_regs
  import rx_link_regs_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire avs_req_t              avs_req,
  output avs_rsp_t                   avs_rsp,
  input  wire logic [DATA_W-1:0]     rx_lane7_in,
  output logic      [DATA_W-1:0]     rx_lane7_out,
  input  wire logic [LANES-2:0]      other_lane_power_off,
  output logic      [LANES-1:0]      lane_power_off,
  input  wire lane_cfg_t [LANES-1:0] cfg_in,
  input  wire logic [ERR_W-1:0]      err_in,
  output logic                       link_reinit_req
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [BE_W-1:0]   be,
                                              input logic [DATA_W-1:0] fm);
    logic [DATA_W-1:0] m;
    m     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & fm;
    merge = (old & ~m) | (wd & m);
  endfunction

  // ---------------------------------------------------------------
  // bus slave: one wait state per access
  // ---------------------------------------------------------------
  logic              ack_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] lane7_ctrl_r;
  logic [DATA_W-1:0] link_ctrl_r;
  logic [DATA_W-1:0] reinit_en_r;
  logic [CFG_WORDS-1:0][DATA_W-1:0] cfg_store_r [LANES];

  wire req_any  = avs_req.read | avs_req.write;
  wire wr_acc   = avs_req.write & ack_r;
  wire hit_lane = hit(avs_req.address, LANE7_CTRL_OFS);
  wire hit_link = hit(avs_req.address, LINK_CTRL_OFS);
  wire hit_rein = hit(avs_req.address, REINIT_EN_OFS);
  wire hit_cfg  = (avs_req.address[ADDR_W-1:4] == CFG_WORD0_OFS[ADDR_W-1:4]);

  wire [SEL_W-1:0]      sel      = link_ctrl_r[SEL_LO_BIT +: SEL_W];
  wire                  sel_ok   = (sel < SEL_W'(LANES));
  wire [LANE_IDX_W-1:0] sel_idx  = sel[LANE_IDX_W-1:0];
  wire [WORD_IDX_W-1:0] word_idx = avs_req.address[2 +: WORD_IDX_W];
  wire [DATA_W-1:0]     cfg_word = sel_ok ? cfg_store_r[sel_idx][word_idx]
                                          : '0;

  // unmapped addresses read zero; reserved bits are already zero
  assign rdata_nxt = hit_lane ? lane7_ctrl_r :
                     hit_link ? link_ctrl_r  :
                     hit_rein ? reinit_en_r  :
                     hit_cfg  ? cfg_word     : '0;

  assign avs_rsp = '{waitrequest: req_any & ~ack_r, readdata: rdata_r};

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      ack_r <= req_any & ~ack_r;
      if (avs_req.read & ~ack_r)
        rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      lane7_ctrl_r <= LANE7_CTRL_RST;
      link_ctrl_r  <= LINK_CTRL_RST;
      reinit_en_r  <= REINIT_EN_RST;
    end
    else if (wr_acc)
    begin
      if (hit_lane)
        lane7_ctrl_r <= merge(lane7_ctrl_r, avs_req.writedata,
                              avs_req.byteenable, LANE7_CTRL_MASK);
      if (hit_link)
        link_ctrl_r <= merge(link_ctrl_r, avs_req.writedata,
                             avs_req.byteenable, LINK_CTRL_MASK);
      if (hit_rein)
        reinit_en_r <= merge(reinit_en_r, avs_req.writedata,
                             avs_req.byteenable, REINIT_EN_MASK);
    end
  end

  // ---------------------------------------------------------------
  // lane 7 datapath and power-off export
  // ---------------------------------------------------------------
  wire invert = lane7_ctrl_r[LANE_INV_BIT];

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rx_lane7_out   <= '0;
      lane_power_off <= '0;
    end
    else
    begin
      rx_lane7_out   <= rx_lane7_in ^ {DATA_W{invert}};
      // vector feeds transport layer lane drop and reset masking
      lane_power_off <= {lane7_ctrl_r[LANE_OFF_BIT],
                         other_lane_power_off};
    end
  end

  // ---------------------------------------------------------------
  // link reinit gating
  // ---------------------------------------------------------------
  wire             reinit_dis = link_ctrl_r[REINIT_DIS_BIT];
  wire [ERR_W-1:0] permit     = reinit_dis ? CODE_GRP_ONLY : '1;
  wire [ERR_W-1:0] err_live   = err_in & reinit_en_r[ERR_W-1:0] & permit;

  always_ff @(posedge mclk)
  begin
    if (srst)
      link_reinit_req <= 1'b0;
    else
      link_reinit_req <= |err_live;
  end

  // ---------------------------------------------------------------
  // per-lane configuration capture
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_cap
      always_ff @(posedge mclk)
      begin
        if (srst)
          cfg_store_r[i] <= '0;
        else if (cfg_in[i].valid)
          cfg_store_r[i] <= cfg_in[i].words;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  wire wr_lane = wr_acc & hit_lane & avs_req.byteenable[0];
  wire rd_cfg  = ack_r & avs_req.read & hit_cfg;

  a_bus_one_wait: assert property (
    req_any && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
    else $error("access not answered after one wait state");

  a_power_off_bit: assert property (
    wr_lane |-> ##2 (lane_power_off[LANE_SEVEN] ==
                     $past(avs_req.writedata[LANE_OFF_BIT], 2)))
    else $error("lane 7 power-off output does not follow write");

  a_invert_path: assert property (
    !$past(srst) && $past(invert) |-> rx_lane7_out == ~$past(rx_lane7_in))
    else $error("lane 7 data not inverted");

  a_pass_path: assert property (
    !$past(srst) && !$past(invert) |-> rx_lane7_out == $past(rx_lane7_in))
    else $error("lane 7 data altered while not inverting");

  a_spare_reset: assert property (
    $past(srst) |-> lane7_ctrl_r == LANE7_CTRL_RST &&
                    link_ctrl_r == LINK_CTRL_RST)
    else $error("control registers wrong after reset");

  a_reserved_zero: assert property (
    (lane7_ctrl_r & ~LANE7_CTRL_MASK) == '0 &&
    (link_ctrl_r & ~LINK_CTRL_MASK) == '0)
    else $error("reserved bits not zero");

  a_reinit_block: assert property (
    $past(reinit_dis) && !$past(err_in[CODE_GRP_BIT]) |-> !link_reinit_req)
    else $error("reinit raised while globally disabled");

  a_reinit_pass: assert property (
    !$past(srst) && !$past(reinit_dis) &&
    $past(|(err_in & reinit_en_r[ERR_W-1:0])) |-> link_reinit_req)
    else $error("enabled error did not raise reinit");

  a_bad_lane_zero: assert property (
    rd_cfg && !sel_ok |-> avs_rsp.readdata == '0)
    else $error("invalid lane selection did not read zero");

  a_sel_routes: assert property (
    rd_cfg && sel_ok |-> avs_rsp.readdata == cfg_store_r[sel_idx][word_idx])
    else $error("selected lane words not routed");

  a_capture_lane: assert property (
    cfg_in[0].valid |=> cfg_store_r[0] == $past(cfg_in[0].words))
    else $error("lane 0 configuration not captured");

  c_lane_write:   cover property (wr_lane ##2 lane_power_off[LANE_SEVEN]);
  c_reinit_block: cover property (reinit_dis && |(err_in & ~CODE_GRP_ONLY));
  c_bad_lane:     cover property (rd_cfg && !sel_ok);
  c_good_lane:    cover property (rd_cfg && sel_ok && sel_idx == LANE_SEVEN);

endmodule // rx_link_regs

`default_nettype wire

//--- verif/tb_top.sv
/*
  Self-checking bench for the lane 7 and link control register bank.
  Assumes the one-wait-state Avalon-MM slave described for the design.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import rx_link_regs_pkg::*;
;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] exp;
  } row_t;

  logic                  mclk = 1'b0;
  logic                  srst = 1'b1;
  avs_req_t              req  = '0;
  avs_rsp_t              rsp;
  logic [DATA_W-1:0]     lane_in = '0;
  logic [DATA_W-1:0]     lane_out;
  logic [LANES-2:0]      other_off = '0;
  logic [LANES-1:0]      power_off;
  lane_cfg_t [LANES-1:0] cfg = '0;
  lane_cfg_t [LANES-1:0] cfg_v = '0;
  int                    pick [3] = '{0, 3, 7};
  logic [ERR_W-1:0]      err = '0;
  logic                  reinit;
  logic [DATA_W-1:0]     q;
  int                    fail_count = 0;
  int                    n_compared = 0;
  row_t                  rows [8];

  rx_link_regs dut (
    .mclk                 (mclk),
    .srst                 (srst),
    .avs_req              (req),
    .avs_rsp              (rsp),
    .rx_lane7_in          (lane_in),
    .rx_lane7_out         (lane_out),
    .other_lane_power_off (other_off),
    .lane_power_off       (power_off),
    .cfg_in               (cfg),
    .err_in               (err),
    .link_reinit_req      (reinit)
  );

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req.read       <= ~wr;
    req.write      <= wr;
    req.address    <= a;
    req.writedata  <= d;
    req.byteenable <= 4'hF;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      $display("ERROR %0t bus request not answered", $time);
      fail_count++;
    end
    q = rsp.readdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] e);
    bus(1'b0, a, '0);
    check(q, e);
  endtask

  // lane l, word w of the captured configuration pattern
  function automatic logic [DATA_W-1:0] word_of(input int l, w);
    word_of = 32'hA0A0_0000 + 32'(w) * 32'h0101_0001
              + 32'(l) * 32'h0000_0100;
  endfunction

  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge mclk);
    $display("ERROR %0t watchdog expired", $time);
    fail_count++;
    end_of_test;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rows[0] = '{LANE7_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0007};
    rows[1] = '{LANE7_CTRL_OFS, 32'h0000_0000, 32'h0000_0000};
    rows[2] = '{LINK_CTRL_OFS,  32'hFFFF_FFFF, 32'h0001_FF80};
    rows[3] = '{LINK_CTRL_OFS,  32'h0000_0000, 32'h0000_0000};
    rows[4] = '{8'hF0,          32'hFFFF_FFFF, 32'h0000_0000};
    rows[5] = '{CFG_WORD0_OFS,  32'hFFFF_FFFF, 32'h0000_0000};
    rows[6] = '{REINIT_EN_OFS,  32'h0000_0000, 32'h0000_0000};
    rows[7] = '{REINIT_EN_OFS,  32'hFFFF_FFFF, 32'h0000_00FF};
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(LANE7_CTRL_OFS, 32'h0000_0004);
    rd_chk(LINK_CTRL_OFS, 32'h0000_0000);
    rd_chk(REINIT_EN_OFS, 32'h0000_00FF);
    check({31'h0, power_off[7]}, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    // power-off and invert together, other lanes passed through
    other_off <= 7'h55;
    bus(1'b1, LANE7_CTRL_OFS, 32'h0000_0003);
    lane_in <= 32'h1234_5678;
    repeat (2) @(posedge mclk);
    check({24'h0, power_off}, 32'h0000_00D5);
    check(lane_out, 32'hEDCB_A987);
    bus(1'b1, LANE7_CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    check(lane_out, 32'h1234_5678);
    check({31'h0, power_off[7]}, 32'h0);
    // reinit gating by the global disable
    err <= 8'h02;
    repeat (2) @(posedge mclk);
    check({31'h0, reinit}, 32'h1);
    err <= 8'h00;
    bus(1'b1, LINK_CTRL_OFS, 32'h0000_1000);
    err <= 8'hFE;
    repeat (2) @(posedge mclk);
    check({31'h0, reinit}, 32'h0);
    err <= CODE_GRP_ONLY;
    repeat (2) @(posedge mclk);
    check({31'h0, reinit}, 32'h1);
    err <= 8'h00;
    // capture all lanes, then select lanes 0, 3, 7 and an absent one
    for (int l = 0; l < LANES; l++)
    begin
      cfg_v[l].valid = 1'b1;
      for (int w = 0; w < CFG_WORDS; w++)
        cfg_v[l].words[w] = word_of(l, w);
    end
    cfg <= cfg_v;
    @(posedge mclk);
    cfg <= '0;
    foreach (pick[k])
    begin
      bus(1'b1, LINK_CTRL_OFS, 32'(pick[k]) << SEL_LO_BIT);
      for (int w = 0; w < CFG_WORDS; w++)
        rd_chk(CFG_WORD0_OFS + 8'(4 * w), word_of(pick[k], w));
    end
    bus(1'b1, LINK_CTRL_OFS, 32'h0000_0400);
    rd_chk(CFG_WORD0_OFS, 32'h0000_0000);
    // mid-run reset restores fields
    bus(1'b1, LANE7_CTRL_OFS, 32'h0000_0003);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(LANE7_CTRL_OFS, 32'h0000_0004);
    rd_chk(LINK_CTRL_OFS, 32'h0000_0000);
    rd_chk(CFG_WORD0_OFS, 32'h0000_0000);
    end_of_test;
  end

endmodule // tb_top

`default_nettype wire
